//--- pkg/ddc_pkg.sv
// Package for the dual converter parallel load controller
`default_nettype none
package ddc_pkg;

  localparam int CODE_W = 16;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID  = 16'h8000;

  // Pin timing in ns, converted to cycles at the 40 ns clock
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_SETUP_NS    = 10;
  localparam int T_PULSE_NS    = 10;
  localparam int T_HOLD_NS     = 0;
  localparam int SETUP_CYC = ((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                             ((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int PULSE_CYC = ((T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                             ((T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int HOLD_CYC  = ((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                             ((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Channel select codes as {hi, lo}
  localparam logic [1:0] SEL_A    = 2'h0;
  localparam logic [1:0] SEL_NONE = 2'h1;
  localparam logic [1:0] SEL_BOTH = 2'h2;
  localparam logic [1:0] SEL_B    = 2'h3;

  // Command codes
  typedef enum logic [2:0] {
    DDC_CMD_WRITE   = 3'h0,
    DDC_CMD_LOAD    = 3'h1,
    DDC_CMD_WR_LOAD = 3'h2,
    DDC_CMD_PULSE   = 3'h3,
    DDC_CMD_CLEAR   = 3'h4
  } ddc_cmd_t;

  typedef struct packed {
    ddc_cmd_t          cmd;
    logic [1:0]        sel;
    logic [CODE_W-1:0] code;
    logic              mid;
  } ddc_req_t;

  typedef struct packed {
    logic [CODE_W-1:0] code_bus;
    logic              channel_sel_hi;
    logic              channel_sel_lo;
    logic              write_n;
    logic              output_load;
    logic              clear_n;
    logic              clear_level_select;
  } ddc_pins_t;

  // Strobe levels that move together at each phase edge
  typedef struct packed {
    logic write_n;
    logic output_load;
    logic clear_n;
  } ddc_strobe_t;

  // Idle pins: no channel selected, strobes inactive, clear released
  localparam ddc_pins_t PINS_IDLE = '{code_bus: CODE_ZERO,
                                      channel_sel_hi: SEL_NONE[1],
                                      channel_sel_lo: SEL_NONE[0],
                                      write_n: 1'b1,
                                      output_load: 1'b0,
                                      clear_n: 1'b1,
                                      clear_level_select: 1'b0};
  localparam ddc_strobe_t STROBE_IDLE = '{write_n: 1'b1, output_load: 1'b0, clear_n: 1'b1};

endpackage
`default_nettype wire

//--- hdl/ddc_host.sv
// Host controller driving the dual converter load pins
`timescale 1ns/1ps
`default_nettype none

// Function
// (R1) Drive 16-bit code bus, two select lines, active-low write strobe per write.
// (R2) Select hi/lo: 00 A, 01 none, 10 both, 11 B.
// (R3) Clear low forces all registers to zero or midscale asynchronously.
// (R4) Write low, load low: selected input registers take the code.
// (R5) Write high, load high: input registers copy into converter registers.
// (R6) Write low, load high: code passes through to converter registers.
// (R7) Tied strobe pulse: capture on fall, transfer on rise.
// (R8) Select lines settle before the write strobe falls.
// (R9) Write both channels separately, then one load updates both together.
// (R10) Clear level select low gives zero, high gives midscale.
// (R11) Code bit 15 is the most significant bit.
// (R12) Write high, load low: nothing changes.
// (R13) Midscale clear value is 0x8000.
module ddc_host
  import ddc_pkg::*;
(
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst_n,
  // Command port
  input  wire logic               req_valid,
  input  wire ddc_pkg::ddc_req_t  req,
  output logic                    req_ready,
  output logic                    done,
  // Device pins
  output var ddc_pkg::ddc_pins_t  pins
);
  import ddc_pkg::*;

  // ==========================================================
  // Sequencer types and state
  typedef enum logic [2:0] {
    DDC_IDLE   = 3'h0,
    DDC_SETUP  = 3'h1,
    DDC_STROBE = 3'h2,
    DDC_HOLD   = 3'h3,
    DDC_DONE   = 3'h4
  } ddc_state_t;

  localparam int CNT_W = 4;

  ddc_state_t       state;
  ddc_state_t       next_state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  ddc_req_t         cur;
  ddc_req_t         next_cur;
  ddc_pins_t        next_pins;
  logic             next_done;
  logic             take;
  logic             phase_end;

  // ==========================================================
  // Helpers
  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n - 1);
  endfunction

  // Strobe levels during the active phase of a command
  function automatic ddc_strobe_t strobe_active(input ddc_cmd_t cmd);
    ddc_strobe_t s;
    s = STROBE_IDLE;
    unique case (cmd)
      DDC_CMD_WRITE: begin
        s.write_n = 1'b0;                                             // (R4)
      end
      DDC_CMD_LOAD: begin
        s.output_load = 1'b1;                                         // (R5) (R9)
      end
      DDC_CMD_WR_LOAD: begin
        s.write_n     = 1'b0;                                         // (R6)
        s.output_load = 1'b1;
      end
      DDC_CMD_PULSE: begin
        // Tied strobe: both low captures the code
        s.write_n     = 1'b0;                                         // (R7)
        s.output_load = 1'b0;
      end
      DDC_CMD_CLEAR: begin
        s.clear_n = 1'b0;                                             // (R3) (R13)
      end
      default: begin
        s = STROBE_IDLE;
      end
    endcase
    return s;
  endfunction

  // Tied strobe returns high together, so its rising edge moves input to converter
  function automatic ddc_strobe_t strobe_release(input ddc_cmd_t cmd);
    ddc_strobe_t s;
    s = STROBE_IDLE;
    if (cmd == DDC_CMD_PULSE) begin
      s.output_load = 1'b1;                                           // (R7)
    end
    return s;
  endfunction

  function automatic ddc_pins_t apply_strobe(input ddc_pins_t p, input ddc_strobe_t s);
    ddc_pins_t r;
    r             = p;
    r.write_n     = s.write_n;
    r.output_load = s.output_load;
    r.clear_n     = s.clear_n;
    return r;
  endfunction

  // ==========================================================
  // Handshake
  assign req_ready = (state == DDC_IDLE);
  assign take      = req_valid && req_ready;
  assign phase_end = (count == '0);

  // ==========================================================
  // Phase sequencer
  always_comb begin
    next_state = state;
    next_count = count;
    unique case (state)
      DDC_IDLE: begin
        if (take) begin
          next_count = cyc(SETUP_CYC);
          next_state = DDC_SETUP;
        end
      end
      DDC_SETUP: begin
        if (phase_end) begin
          next_count = cyc(PULSE_CYC);
          next_state = DDC_STROBE;
        end else begin
          next_count = count - 1'b1;
        end
      end
      DDC_STROBE: begin
        if (phase_end) begin
          next_count = cyc(HOLD_CYC);
          next_state = DDC_HOLD;
        end else begin
          next_count = count - 1'b1;
        end
      end
      DDC_HOLD: begin
        if (phase_end) begin
          next_state = DDC_DONE;
        end else begin
          next_count = count - 1'b1;
        end
      end
      DDC_DONE: begin
        next_state = DDC_IDLE;
      end
      default: begin
        next_count = '0;
        next_state = DDC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= DDC_IDLE;
      count <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // ==========================================================
  // Request capture
  always_comb begin
    next_cur = cur;
    if (take) begin
      next_cur = req;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // ==========================================================
  // Pin drive
  always_comb begin
    next_pins = pins;
    unique case (state)
      DDC_IDLE: begin
        if (take) begin
          // Code and select settle a full phase ahead of any strobe
          next_pins.code_bus           = req.code;                    // (R1) (R11)
          next_pins.channel_sel_hi     = req.sel[1];                  // (R2)
          next_pins.channel_sel_lo     = req.sel[0];                  // (R2)
          next_pins.clear_level_select = req.mid;                     // (R10)
        end
      end
      DDC_SETUP: begin
        if (phase_end) begin
          next_pins = apply_strobe(pins, strobe_active(cur.cmd));     // (R8)
        end
      end
      DDC_STROBE: begin
        if (phase_end) begin
          next_pins = apply_strobe(pins, strobe_release(cur.cmd));    // (R7)
        end
      end
      DDC_HOLD: begin
        if (phase_end) begin
          // Write high, load low leaves the registers alone
          next_pins = apply_strobe(pins, STROBE_IDLE);                // (R12)
        end
      end
      DDC_DONE: begin
        next_pins = pins;
      end
      default: begin
        next_pins = apply_strobe(pins, STROBE_IDLE);
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pins <= PINS_IDLE;
    end else begin
      pins <= next_pins;
    end
  end

  // ==========================================================
  // Completion pulse
  always_comb begin
    next_done = (state == DDC_DONE);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else begin
      done <= next_done;
    end
  end

endmodule
`default_nettype wire

//--- tb/ddc_host_sva.sv
// Pin checker for the host load controller
`timescale 1ns/1ps
`default_nettype none
module ddc_host_sva
  import ddc_pkg::*;
(
  // Clock and command port
  input wire logic               clock,
  input wire logic               rst_n,
  input wire logic               req_valid,
  input wire ddc_pkg::ddc_req_t  req,
  input wire logic               req_ready,
  input wire logic               done,
  // Device pins
  input wire ddc_pkg::ddc_pins_t pins
);
  // ==========
  // Properties
  logic [15:0] code_q;
  always_ff @(posedge clock) if (req_valid && req_ready) code_q <= req.code;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_sel; $fell(pins.write_n) |-> $stable({pins.channel_sel_hi, pins.channel_sel_lo}); endproperty
  a_sel: assert property (p_sel) else $error("select moved at strobe");
  property p_wr; $fell(pins.write_n) |=> pins.write_n; endproperty
  a_wr: assert property (p_wr) else $error("write strobe not one cycle");
  property p_code; $fell(pins.write_n) |-> pins.code_bus == code_q; endproperty
  a_code: assert property (p_code) else $error("code bus differs");
  property p_ld; $rose(pins.output_load) |=> !pins.output_load; endproperty
  a_ld: assert property (p_ld) else $error("load not one cycle");
  property p_done; req_valid && req_ready |-> ##[5:6] done; endproperty
  a_done: assert property (p_done) else $error("done missing");
  property p_clr; $fell(pins.clear_n) |=> pins.clear_n; endproperty
  a_clr: assert property (p_clr) else $error("clear not one cycle");
  property p_lvl; $fell(pins.clear_n) |-> $stable(pins.clear_level_select); endproperty
  a_lvl: assert property (p_lvl) else $error("clear level moved at clear");
  property p_idle; req_ready |-> pins.write_n && !pins.output_load && pins.clear_n; endproperty
  a_idle: assert property (p_idle) else $error("strobe active while idle");
endmodule
bind ddc_host ddc_host_sva i_ddc_host_sva (.clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .done(done), .pins(pins));
`default_nettype wire

//--- tb/ddc_dev_model.sv
// Level model of the dual converter register logic
`timescale 1ns/1ps
`default_nettype none
module ddc_dev_model
  import ddc_pkg::*;
(
  // Device pins
  input wire ddc_pkg::ddc_pins_t pins,
  // Converter registers
  output var logic [15:0]        conv_a,
  output var logic [15:0]        conv_b
);
  // ==========
  // Registers
  logic [15:0] in_a;
  logic [15:0] in_b;
  logic [1:0]  sel;
  // Input stage before output stage, so write low with load high passes fresh code through
  always @(pins) begin
    sel = {pins.channel_sel_hi, pins.channel_sel_lo};
    if (!pins.clear_n) begin
      in_a = pins.clear_level_select ? CODE_MID : CODE_ZERO;
      in_b = in_a;
      conv_a = in_a;
      conv_b = in_a;
    end else begin
      if (!pins.write_n && (sel == SEL_A || sel == SEL_BOTH)) in_a = pins.code_bus;
      if (!pins.write_n && (sel == SEL_B || sel == SEL_BOTH)) in_b = pins.code_bus;
      if (pins.output_load) begin
        conv_a = in_a;
        conv_b = in_b;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/tb.sv
// Testbench for the host load controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ddc_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        req_valid = 1'b0;
  ddc_req_t    req = '0;
  logic        req_ready;
  logic        done;
  ddc_pins_t   pins;
  logic [15:0] ca;
  logic [15:0] cb;
  int          errors = 0;
  int          total_checks = 0;
  always #20 clock = ~clock;
  ddc_host i_ddc_host (.clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .done(done), .pins(pins));
  ddc_dev_model i_ddc_dev_model (.pins(pins), .conv_a(ca), .conv_b(cb));
  // ==========
  // Tasks
  task automatic test_done;
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded waits: a hung handshake ends the run
  task automatic run(input ddc_cmd_t c, input logic [1:0] s, input logic [15:0] d, input logic m);
    int n;
    n = 0;
    req <= '{cmd: c, sel: s, code: d, mid: m};
    req_valid <= 1'b1;
    do @(posedge clock); while (req_ready !== 1'b1 && ++n < 50);
    req_valid <= 1'b0;
    do @(posedge clock); while (done !== 1'b1 && ++n < 50);
    if (n >= 50) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, done, 1'b1);
      test_done();
    end
  endtask
  task automatic t_clear;
    run(DDC_CMD_CLEAR, SEL_A, 16'hFFFF, 1'b0);
    chk(ca | cb, CODE_ZERO);
    run(DDC_CMD_CLEAR, SEL_A, 16'h0000, 1'b1);
    chk(ca, CODE_MID);
    chk(cb, CODE_MID);
    // A load after the midscale clear shows the input registers were cleared too
    run(DDC_CMD_LOAD, SEL_NONE, 16'h0000, 1'b1);
    chk(ca, CODE_MID);
    chk(cb, CODE_MID);
  endtask
  task automatic t_stage;
    run(DDC_CMD_WRITE, SEL_A, 16'h1234, 1'b0);
    run(DDC_CMD_WRITE, SEL_B, 16'hABCD, 1'b0);
    run(DDC_CMD_WRITE, SEL_NONE, 16'hFFFF, 1'b0);
    chk(ca, CODE_MID);
    chk(cb, CODE_MID);
    run(DDC_CMD_LOAD, SEL_NONE, 16'h0000, 1'b0);
    chk(ca, 16'h1234);
    chk(cb, 16'hABCD);
  endtask
  task automatic t_pass;
    run(DDC_CMD_WR_LOAD, SEL_BOTH, 16'h8001, 1'b0);
    chk(ca, 16'h8001);
    chk(cb, 16'h8001);
    run(DDC_CMD_PULSE, SEL_B, 16'h7FFE, 1'b0);
    chk(cb, 16'h7FFE);
    chk(ca, 16'h8001);
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_clear();
    t_stage();
    t_pass();
    test_done();
  end
endmodule
`default_nettype wire
